// file: csb_unit.sv
// Compare, conditional skip and conditional branch execution unit
//
// Contract
// - Equal registers skip next instruction, flags kept
// - Register compare sets flags, with-carry subtracts carry
// - Constant compare sets flags, no write back
// - Register bit clear skips next instruction
// - Register bit set skips next instruction
// - I/O bit clear skips next instruction
// - I/O bit set skips next instruction
// - Chosen flag set branches to pc+offset+1
// - Chosen flag clear branches to pc+offset+1
// - Zero set branches to pc+offset+1
// - Zero clear branches to pc+offset+1
// - Carry set branches to pc+offset+1
// - Carry clear branches to pc+offset+1
`timescale 1ns/1ps
`default_nettype none
module csb_unit (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  var csb_pkg::csb_req_s  REQ,
	output logic [15:0]            PC,
	output logic [7:0]             STATUS_FLAGS,
	output logic                   DONE,
	output logic                   TAKEN
);
	import csb_pkg::*;

	// ========================================================
	// State
	typedef struct packed {
		logic [15:0] pc;
		logic [7:0]  flags;
		logic        done;
		logic        taken;
	} csb_state_s;

	csb_state_s st;
	csb_state_s next_st;

	// ========================================================
	// Arithmetic and condition helpers
	logic [7:0] cmp_b;
	logic       use_cin;
	logic [7:0] cmp_flags;
	logic       skip;
	logic       branch;
	logic       is_cmp;

	// Constant compare uses the immediate, others the source register
	always_comb begin
		cmp_b   = (REQ.op == OP_COMPARE_WITH_CONSTANT) ? REQ.k_const : REQ.rr;
		use_cin = (REQ.op == OP_COMPARE_REGISTERS_WITH_CARRY);
		is_cmp  = (REQ.op == OP_COMPARE_REGISTERS)
			| (REQ.op == OP_COMPARE_REGISTERS_WITH_CARRY)
			| (REQ.op == OP_COMPARE_WITH_CONSTANT);
	end

	csb_sub_flags u_sub (
		.a         (REQ.rd),
		.b         (cmp_b),
		.cin       (st.flags[FLAG_C]),
		.use_cin   (use_cin),
		.flags_in  (st.flags),
		.flags_out (cmp_flags)
	);

	csb_cond u_cond (
		.req    (REQ),
		.flags  (st.flags),
		.skip   (skip),
		.branch (branch)
	);

	// ========================================================
	// Next state: flags only move on compares, pc on every request
	always_comb begin
		next_st       = st;
		next_st.done  = 1'b0;
		next_st.taken = 1'b0;
		if (REQ.valid) begin
			next_st.done = 1'b1;
			next_st.pc   = st.pc + PC_STEP;
			if (is_cmp) begin
				next_st.flags = cmp_flags;
			end
			if (skip) begin
				// Skip length depends on the size of the skipped instruction
				next_st.pc    = st.pc + (REQ.next_two_words ? SKIP_TWO_WORDS
					: SKIP_ONE_WORD);
				next_st.taken = 1'b1;
			end else if (branch) begin
				// Sign-extend the 7-bit offset before the add
				next_st.pc    = st.pc + {{9{REQ.offset[6]}}, REQ.offset} + PC_STEP;
				next_st.taken = 1'b1;
			end
		end
	end

	// Register the state
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st.pc    <= PC_RESET;
			st.flags <= FLAGS_RESET;
			st.done  <= 1'b0;
			st.taken <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign PC           = st.pc;
	assign STATUS_FLAGS = st.flags;
	assign DONE         = st.done;
	assign TAKEN        = st.taken;

	// ========================================================
	// Checks
	chk_skip_flags_kept: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && !is_cmp) |=> (STATUS_FLAGS == $past(STATUS_FLAGS)))
		else $error("flags changed on a non-compare");
	chk_cmp_carry: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_REGISTERS)
		|=> (STATUS_FLAGS[FLAG_C] == ($past(REQ.rd) < $past(REQ.rr))))
		else $error("compare carry wrong");
	chk_const_zero: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_WITH_CONSTANT)
		|=> (STATUS_FLAGS[FLAG_Z] == ($past(REQ.rd) == $past(REQ.k_const))))
		else $error("constant compare zero wrong");
	chk_eq_skip_len: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_SKIP_EQUAL && REQ.rd == REQ.rr)
		|=> (PC == $past(PC) + ($past(REQ.next_two_words) ? 16'h0003 : 16'h0002)))
		else $error("skip length wrong");
	chk_io_skip: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_IO_BIT_SET && !REQ.io_data[REQ.bit_sel])
		|=> (PC == $past(PC) + 16'h0001 && !TAKEN))
		else $error("io skip taken wrongly");
	chk_reg_clear: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_REG_BIT_CLEAR && !REQ.rr[REQ.bit_sel])
		|=> TAKEN)
		else $error("reg bit clear skip missed");
	chk_beq_target: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_EQUAL && STATUS_FLAGS[FLAG_Z])
		|=> (PC == $past(PC) + {{9{$past(REQ.offset[6])}}, $past(REQ.offset)} + 16'h0001))
		else $error("branch target wrong");
	chk_bcc_hold: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_CARRY_CLEAR && STATUS_FLAGS[FLAG_C])
		|=> (PC == $past(PC) + 16'h0001 && !TAKEN))
		else $error("carry clear branch taken wrongly");
	chk_idle_hold: assert property (@(posedge CLK) disable iff (RST)
		!REQ.valid |=> (!DONE && PC == $past(PC)))
		else $error("state moved without request");

	// ========================================================
	// Compare flag checks, worked out without the borrow chain

	// Plain compare sets zero exactly when the operands match
	chk_cmp_zero: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_REGISTERS)
		|=> (STATUS_FLAGS[FLAG_Z] == ($past(REQ.rd) == $past(REQ.rr))))
		else $error("compare zero wrong");

	// Negative mirrors the top bit of the discarded difference
	chk_cmp_negative: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_REGISTERS)
		|=> (STATUS_FLAGS[FLAG_N]
			== ((($past(REQ.rd) - $past(REQ.rr)) & 8'h80) != 8'h00)))
		else $error("compare negative wrong");

	// Sign flag must tell a signed less-than, whatever the overflow
	chk_cmp_sign: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_REGISTERS)
		|=> (STATUS_FLAGS[FLAG_S] == ($signed($past(REQ.rd)) < $signed($past(REQ.rr)))))
		else $error("compare sign wrong");

	// With carry, a borrow comes when source plus carry exceeds destination
	chk_cmpc_carry: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_REGISTERS_WITH_CARRY)
		|=> (STATUS_FLAGS[FLAG_C] == ({1'b0, $past(REQ.rd)}
			< ({1'b0, $past(REQ.rr)} + {8'h00, $past(STATUS_FLAGS[FLAG_C])}))))
		else $error("carry compare borrow wrong");

	// A chained compare can clear zero but never set it afresh
	chk_cmpc_zero: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_REGISTERS_WITH_CARRY)
		|=> (STATUS_FLAGS[FLAG_Z] == ($past(STATUS_FLAGS[FLAG_Z])
			&& ($past(REQ.rd) == $past(REQ.rr) + {7'h00, $past(STATUS_FLAGS[FLAG_C])}))))
		else $error("carry compare zero wrong");

	// Constant compare borrows when the constant is the larger
	chk_const_carry: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_WITH_CONSTANT)
		|=> (STATUS_FLAGS[FLAG_C] == ($past(REQ.rd) < $past(REQ.k_const))))
		else $error("constant compare carry wrong");

	// Compares never skip, so they only step past themselves
	chk_cmp_pc_step: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && is_cmp)
		|=> (PC == $past(PC) + PC_STEP && !TAKEN))
		else $error("compare moved pc wrongly");

	// Bits above the sign flag belong to other units and never move here
	chk_upper_flags: assert property (@(posedge CLK) disable iff (RST)
		REQ.valid |=> (STATUS_FLAGS[7:5] == $past(STATUS_FLAGS[7:5])))
		else $error("upper flags changed");

	// ========================================================
	// Skip checks, both the taken and the fall-through side

	// Unequal registers fall through to the next instruction
	chk_eq_no_skip: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_COMPARE_SKIP_EQUAL && REQ.rd != REQ.rr)
		|=> (PC == $past(PC) + PC_STEP && !TAKEN))
		else $error("unequal compare skipped");

	// A set bit under the clear test does not skip
	chk_reg_clear_hold: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_REG_BIT_CLEAR && REQ.rr[REQ.bit_sel])
		|=> (PC == $past(PC) + PC_STEP && !TAKEN))
		else $error("reg bit clear skip taken wrongly");

	// A set register bit under the set test skips
	chk_reg_set_skip: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_REG_BIT_SET && REQ.rr[REQ.bit_sel])
		|=> TAKEN)
		else $error("reg bit set skip missed");

	// A clear register bit under the set test falls through
	chk_reg_set_hold: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_REG_BIT_SET && !REQ.rr[REQ.bit_sel])
		|=> (PC == $past(PC) + PC_STEP && !TAKEN))
		else $error("reg bit set skip taken wrongly");

	// A clear I/O bit under the clear test skips
	chk_io_clear_skip: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_IO_BIT_CLEAR && !REQ.io_data[REQ.bit_sel])
		|=> TAKEN)
		else $error("io bit clear skip missed");

	// A set I/O bit under the clear test falls through
	chk_io_clear_hold: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_IO_BIT_CLEAR && REQ.io_data[REQ.bit_sel])
		|=> (PC == $past(PC) + PC_STEP && !TAKEN))
		else $error("io bit clear skip taken wrongly");

	// A set I/O bit under the set test skips
	chk_io_set_skip: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_IO_BIT_SET && REQ.io_data[REQ.bit_sel])
		|=> TAKEN)
		else $error("io bit set skip missed");

	// Register bit-clear skips take the same length rule as the equality skip
	chk_bit_skip_len: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_SKIP_REG_BIT_CLEAR && !REQ.rr[REQ.bit_sel])
		|=> (PC == $past(PC)
			+ ($past(REQ.next_two_words) ? SKIP_TWO_WORDS : SKIP_ONE_WORD)))
		else $error("bit skip length wrong");

	// ========================================================
	// Branch checks, target and fall-through

	// Chosen flag set jumps to the relative target
	chk_flag_set_jump: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_FLAG_SET && STATUS_FLAGS[REQ.bit_sel])
		|=> (TAKEN && PC == $past(PC) + 16'($signed($past(REQ.offset))) + PC_STEP))
		else $error("flag set branch target wrong");

	// Chosen flag clear under the set test falls through
	chk_flag_set_hold: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_FLAG_SET && !STATUS_FLAGS[REQ.bit_sel])
		|=> (PC == $past(PC) + PC_STEP && !TAKEN))
		else $error("flag set branch taken wrongly");

	// Chosen flag clear jumps to the relative target
	chk_flag_clear_jump: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_FLAG_CLEAR && !STATUS_FLAGS[REQ.bit_sel])
		|=> (TAKEN && PC == $past(PC) + 16'($signed($past(REQ.offset))) + PC_STEP))
		else $error("flag clear branch target wrong");

	// Chosen flag set under the clear test falls through
	chk_flag_clear_hold: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_FLAG_CLEAR && STATUS_FLAGS[REQ.bit_sel])
		|=> (PC == $past(PC) + PC_STEP && !TAKEN))
		else $error("flag clear branch taken wrongly");

	// Zero clear keeps the equal branch in sequence
	chk_equal_hold: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_EQUAL && !STATUS_FLAGS[FLAG_Z])
		|=> (PC == $past(PC) + PC_STEP && !TAKEN))
		else $error("equal branch taken wrongly");

	// Zero clear takes the not-equal branch
	chk_not_equal_jump: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_NOT_EQUAL && !STATUS_FLAGS[FLAG_Z])
		|=> (TAKEN && PC == $past(PC) + 16'($signed($past(REQ.offset))) + PC_STEP))
		else $error("not equal branch target wrong");

	// Carry set takes the carry-set branch
	chk_carry_set_jump: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_CARRY_SET && STATUS_FLAGS[FLAG_C])
		|=> (TAKEN && PC == $past(PC) + 16'($signed($past(REQ.offset))) + PC_STEP))
		else $error("carry set branch target wrong");

	// Carry clear takes the carry-clear branch
	chk_carry_clear_jump: assert property (@(posedge CLK) disable iff (RST)
		(REQ.valid && REQ.op == OP_BRANCH_CARRY_CLEAR && !STATUS_FLAGS[FLAG_C])
		|=> (TAKEN && PC == $past(PC) + 16'($signed($past(REQ.offset))) + PC_STEP))
		else $error("carry clear branch target wrong");

	// ========================================================
	// Completion pulses

	// Every accepted request is answered exactly one cycle later
	chk_done_pulse: assert property (@(posedge CLK) disable iff (RST)
		REQ.valid |=> DONE)
		else $error("request not answered");

	// A taken flag without a finished request would mislead fetch
	chk_taken_with_done: assert property (@(posedge CLK) disable iff (RST)
		TAKEN |-> DONE)
		else $error("taken without done");

endmodule
`default_nettype wire

// file: csb_pkg.sv
// Shared types and constants for the compare, skip and branch unit
package csb_pkg;

	// ========================================================
	// Operation codes presented by the decode stage
	typedef enum logic [3:0] {
		OP_NONE,
		OP_COMPARE_SKIP_EQUAL,
		OP_COMPARE_REGISTERS,
		OP_COMPARE_REGISTERS_WITH_CARRY,
		OP_COMPARE_WITH_CONSTANT,
		OP_SKIP_REG_BIT_CLEAR,
		OP_SKIP_REG_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR,
		OP_SKIP_IO_BIT_SET,
		OP_BRANCH_FLAG_SET,
		OP_BRANCH_FLAG_CLEAR,
		OP_BRANCH_EQUAL,
		OP_BRANCH_NOT_EQUAL,
		OP_BRANCH_CARRY_SET,
		OP_BRANCH_CARRY_CLEAR
	} csb_op_e;

	// ========================================================
	// Status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;

	// Program counter width and advances
	localparam int          PC_W           = 16;
	localparam logic [15:0] PC_STEP        = 16'h0001;
	localparam logic [15:0] SKIP_ONE_WORD  = 16'h0002;
	localparam logic [15:0] SKIP_TWO_WORDS = 16'h0003;
	localparam logic [15:0] PC_RESET       = 16'h0000;
	localparam logic [7:0]  FLAGS_RESET    = 8'h00;

	// ========================================================
	// One request from decode
	typedef struct packed {
		logic        valid;
		csb_op_e     op;
		logic [7:0]  rd;
		logic [7:0]  rr;
		logic [7:0]  k_const;
		logic [2:0]  bit_sel;
		logic [7:0]  io_data;
		logic [6:0]  offset;
		logic        next_two_words;
	} csb_req_s;

	// Flag results of a subtraction
	typedef struct packed {
		logic [7:0] flags;
	} csb_flags_s;

endpackage

// file: csb_sub_flags.sv
// Subtract-and-flag unit used by all compare operations
`timescale 1ns/1ps
`default_nettype none
module csb_sub_flags (
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	input  wire logic       use_cin,
	input  wire logic [7:0] flags_in,
	output logic      [7:0] flags_out
);
	import csb_pkg::*;

	// ========================================================
	// Difference and flag formation
	logic [8:0] diff;
	logic       n_bit;
	logic       v_bit;
	logic       z_new;
	always_comb begin
		diff  = {1'b0, a} - {1'b0, b} - {8'h00, (use_cin & cin)};
		n_bit = diff[7];
		v_bit = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
		// With carry, zero only stays set, so multi-byte compares chain
		z_new = (diff[7:0] == 8'h00) & (~use_cin | flags_in[FLAG_Z]);
		flags_out         = flags_in;
		flags_out[FLAG_C] = diff[8];
		flags_out[FLAG_Z] = z_new;
		flags_out[FLAG_N] = n_bit;
		flags_out[FLAG_V] = v_bit;
		flags_out[FLAG_S] = n_bit ^ v_bit;
	end
endmodule
`default_nettype wire

// file: csb_cond.sv
// Skip and branch condition evaluation
`timescale 1ns/1ps
`default_nettype none
module csb_cond (
	input  var csb_pkg::csb_req_s req,
	input  wire logic [7:0]       flags,
	output logic                  skip,
	output logic                  branch
);
	import csb_pkg::*;

	// ========================================================
	// Conditions per operation
	always_comb begin
		skip   = 1'b0;
		branch = 1'b0;
		unique case (req.op)
			OP_COMPARE_SKIP_EQUAL: skip   = (req.rd == req.rr);
			OP_SKIP_REG_BIT_CLEAR: skip   = ~req.rr[req.bit_sel];
			OP_SKIP_REG_BIT_SET:   skip   = req.rr[req.bit_sel];
			OP_SKIP_IO_BIT_CLEAR:  skip   = ~req.io_data[req.bit_sel];
			OP_SKIP_IO_BIT_SET:    skip   = req.io_data[req.bit_sel];
			OP_BRANCH_FLAG_SET:    branch = flags[req.bit_sel];
			OP_BRANCH_FLAG_CLEAR:  branch = ~flags[req.bit_sel];
			OP_BRANCH_EQUAL:       branch = flags[FLAG_Z];
			OP_BRANCH_NOT_EQUAL:   branch = ~flags[FLAG_Z];
			OP_BRANCH_CARRY_SET:   branch = flags[FLAG_C];
			OP_BRANCH_CARRY_CLEAR: branch = ~flags[FLAG_C];
			default: begin
				skip   = 1'b0;
				branch = 1'b0;
			end
		endcase
	end
endmodule
`default_nettype wire

// file: tb_compare_skip_branch_unit.sv
// Self-checking testbench for the compare, skip and branch unit
`timescale 1ns/1ps
`default_nettype none
module tb_compare_skip_branch_unit;
	import csb_pkg::*;
	localparam logic [7:0] PAT = 8'ha5;
	logic        CLK = 1'h0;
	logic        RST = 1'h1;
	csb_req_s    r = '0;
	logic [15:0] pc;
	logic [7:0]  fl_o;
	logic        done;
	logic        taken;
	logic [15:0] epc = 16'h0000;
	logic [7:0]  ef = 8'h00;
	int          n_fail = 0;
	int          total_checks = 0;

	// ====
	// 200 MHz clock
	always #2.5 CLK = ~CLK;

	csb_unit u_dut (.CLK(CLK), .RST(RST), .REQ(r), .PC(pc), .STATUS_FLAGS(fl_o),
		.DONE(done), .TAKEN(taken));

	// ====
	// Compare tasks, narrow kinds widen to the program counter width
	task chk16(input string n, input logic [15:0] e, input logic [15:0] s);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		chk16(n, {8'h00, e}, {8'h00, s});
	endtask
	task chk1(input string n, input logic e, input logic s);
		chk16(n, {15'h0000, e}, {15'h0000, s});
	endtask

	// Valid stays up between calls so back-to-back requests never toggle it
	task fire(input logic t, input logic [15:0] adv);
		r.valid = 1'h1;
		@(posedge CLK);
		#1;
		epc = epc + (t ? adv : PC_STEP);
		chk16("pc", epc, pc);
		chk8("flags", ef, fl_o);
		chk1("done", 1'h1, done);
		chk1("taken", t, taken);
	endtask

	// Constant field gets the inverse of rr so a wrong operand pick shows
	task op(input csb_op_e o, input logic [7:0] a, input logic [7:0] b, input logic [2:0] s,
		input logic [6:0] k, input logic tw, input logic t, input logic [15:0] adv);
		r.op = o;
		r.rd = a;
		r.rr = b;
		r.k_const = ~b;
		r.bit_sel = s;
		r.io_data = a;
		r.offset = k;
		r.next_two_words = tw;
		fire(t, adv);
	endtask

	function automatic logic [15:0] rel(input logic [6:0] k);
		return {{9{k[6]}}, k} + PC_STEP;
	endfunction

	// Flags of a compare, zero is sticky along a with-carry chain
	task cmp(input csb_op_e o, input logic [7:0] a, input logic [7:0] b);
		logic [8:0] d;
		logic       wc;
		wc = (o == OP_COMPARE_REGISTERS_WITH_CARRY);
		d = {1'h0, a} - {1'h0, b} - {8'h00, wc & ef[FLAG_C]};
		ef[FLAG_Z] = (d[7:0] == 8'h00) & (~wc | ef[FLAG_Z]);
		ef[FLAG_C] = d[8];
		ef[FLAG_N] = d[7];
		ef[FLAG_V] = (a[7] & ~b[7] & ~d[7]) | (~a[7] & b[7] & d[7]);
		ef[FLAG_S] = ef[FLAG_N] ^ ef[FLAG_V];
		op(o, a, (o == OP_COMPARE_WITH_CONSTANT) ? ~b : b, 3'h0, 7'h00, 1'h0, 1'h0, PC_STEP);
	endtask

	// ====
	// Scenarios
	task t_compare;
		cmp(OP_COMPARE_REGISTERS, 8'h01, 8'h02);
		cmp(OP_COMPARE_REGISTERS_WITH_CARRY, 8'h12, 8'h11);
		cmp(OP_COMPARE_REGISTERS, 8'h80, 8'h01);
		cmp(OP_COMPARE_WITH_CONSTANT, 8'h33, 8'h33);
		cmp(OP_COMPARE_REGISTERS_WITH_CARRY, 8'h40, 8'h40);
		cmp(OP_COMPARE_WITH_CONSTANT, 8'h10, 8'h90);
		op(OP_NONE, 8'h00, 8'h00, 3'h0, 7'h00, 1'h0, 1'h0, PC_STEP);
	endtask
	task t_skip_equal;
		op(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 3'h0, 7'h00, 1'h0, 1'h1, SKIP_ONE_WORD);
		op(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5a, 3'h0, 7'h00, 1'h1, 1'h1, SKIP_TWO_WORDS);
		op(OP_COMPARE_SKIP_EQUAL, 8'h5a, 8'h5b, 3'h0, 7'h00, 1'h1, 1'h0, PC_STEP);
	endtask
	task t_skip_bits;
		logic [15:0] adv;
		for (int i = 0; i < 8; i++) begin
			adv = i[0] ? SKIP_TWO_WORDS : SKIP_ONE_WORD;
			op(OP_SKIP_REG_BIT_CLEAR, PAT, PAT, i[2:0], 7'h00, i[0], ~PAT[i], adv);
			op(OP_SKIP_REG_BIT_SET, PAT, PAT, i[2:0], 7'h00, i[0], PAT[i], adv);
			op(OP_SKIP_IO_BIT_CLEAR, PAT, ~PAT, i[2:0], 7'h00, i[0], ~PAT[i], adv);
			op(OP_SKIP_IO_BIT_SET, PAT, ~PAT, i[2:0], 7'h00, i[0], PAT[i], adv);
		end
	endtask
	task t_branch;
		for (int j = 0; j < 2; j++) begin
			cmp(OP_COMPARE_REGISTERS, 8'h05, j ? 8'h05 : 8'h06);
			for (int i = 0; i < 5; i++) begin
				op(OP_BRANCH_FLAG_SET, 8'h00, 8'h00, i[2:0], 7'h7e, 1'h0, ef[i], rel(7'h7e));
				op(OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, i[2:0], 7'h05, 1'h0, ~ef[i], rel(7'h05));
			end
			op(OP_BRANCH_EQUAL, 8'h00, 8'h00, 3'h4, 7'h40, 1'h0, ef[FLAG_Z], rel(7'h40));
			op(OP_BRANCH_NOT_EQUAL, 8'h00, 8'h00, 3'h4, 7'h3f, 1'h0, ~ef[FLAG_Z], rel(7'h3f));
			op(OP_BRANCH_CARRY_SET, 8'h00, 8'h00, 3'h2, 7'h7f, 1'h0, ef[FLAG_C], rel(7'h7f));
			op(OP_BRANCH_CARRY_CLEAR, 8'h00, 8'h00, 3'h2, 7'h01, 1'h0, ~ef[FLAG_C], rel(7'h01));
		end
	endtask
	// Pulses must drop when idle, a mid-run reset clears state at once,
	// and the unit restarts from zero on the first edge after release
	task t_idle_reset;
		r.valid = 1'h0;
		@(posedge CLK);
		#1;
		chk1("done", 1'h0, done);
		chk1("taken", 1'h0, taken);
		chk16("pc", epc, pc);
		op(OP_COMPARE_SKIP_EQUAL, 8'h11, 8'h11, 3'h0, 7'h00, 1'h0, 1'h1, SKIP_ONE_WORD);
		RST = 1'h1;
		#1;
		chk16("pc", PC_RESET, pc);
		chk8("flags", FLAGS_RESET, fl_o);
		chk1("done", 1'h0, done);
		chk1("taken", 1'h0, taken);
		epc = PC_RESET;
		ef = FLAGS_RESET;
		@(posedge CLK);
		#1;
		RST = 1'h0;
		op(OP_BRANCH_NOT_EQUAL, 8'h00, 8'h00, 3'h0, 7'h05, 1'h0, 1'h1, rel(7'h05));
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog cuts a hang short
	initial begin
		#200000;
		n_fail++;
		close_out;
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge CLK);
		#1;
		RST = 1'h0;
		chk16("pc", PC_RESET, pc);
		chk8("flags", FLAGS_RESET, fl_o);
		t_compare;
		t_skip_equal;
		t_skip_bits;
		t_branch;
		t_idle_reset;
		close_out;
	end
endmodule
`default_nettype wire
